// ===== verilog/dpi2c_pkg.sv
`default_nettype none
package dpi2c_pkg;
   // system clock rate and one quarter of an scl period
   localparam int CLK_KHZ = 40000;
   localparam int T_QTR_NS = 700;
   // rounded up: a shorter quarter would break the low-time minimum
   localparam int QTR_CYC = (T_QTR_NS * CLK_KHZ + 999999) / 1000000;
   localparam int QTR_W = 5;
   localparam logic [QTR_W-1:0] QTR_LAST = QTR_W'(QTR_CYC - 1);
   localparam logic [QTR_W-1:0] QTR_ZERO = 5'h00;

   // target address: fixed upper bits, low bits from the strap
   localparam logic [4:0] ADDR_HI = 5'h0A;
   localparam logic [1:0] ALO_GND = 2'h0;
   localparam logic [1:0] ALO_OPEN = 2'h1;
   localparam logic [1:0] ALO_SUPPLY = 2'h3;
   localparam logic [6:0] GCALL_ADDR = 7'h00;
   localparam logic [7:0] GCALL_RESET = 8'h06;
   localparam logic [7:0] CMD_WIPER = 8'h00;
   localparam logic [7:0] CMD_CONFIG = 8'h80;
   localparam logic RW_WRITE = 1'b0;
   localparam logic RW_READ = 1'b1;
   localparam logic [7:0] BYTE_IDLE = 8'hFF;

   // bit counter, byte positions, quarters, retries
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [2:0] BIT_ZERO = 3'h0;
   localparam logic [1:0] POS_ADDR = 2'h0;
   localparam logic [1:0] POS_CMD = 2'h1;
   localparam logic [1:0] POS_DATA = 2'h2;
   localparam logic [1:0] POS_RX = 2'h3;
   localparam logic [1:0] Q_0 = 2'h0;
   localparam logic [1:0] Q_1 = 2'h1;
   localparam logic [1:0] Q_2 = 2'h2;
   localparam logic [1:0] Q_3 = 2'h3;
   localparam logic [1:0] RETRY_MAX = 2'h3;
   localparam logic [7:0] HI_SAT = 8'hFF;

   typedef enum logic [1:0] {
      OP_WRITE = 2'h0,
      OP_READ = 2'h1,
      OP_GCALL = 2'h2
   } dpi2c_op_e;

   typedef enum logic [1:0] {
      SEL_GND = 2'h0,
      SEL_OPEN = 2'h1,
      SEL_SUPPLY = 2'h2
   } dpi2c_asel_e;

   typedef struct packed {
      dpi2c_op_e op;
      logic [7:0] cmd;
      logic [7:0] data;
   } dpi2c_req_s;

   typedef struct packed {
      logic ok;
      logic [1:0] tries;
      logic [7:0] rdata;
   } dpi2c_rsp_s;

   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_START = 7'h02,
      ST_BYTE = 7'h04,
      ST_ACK = 7'h08,
      ST_RSTART = 7'h10,
      ST_STOP = 7'h20,
      ST_FIN = 7'h40
   } dpi2c_st_e;
endpackage
`default_nettype wire

// ===== verilog/dpi2c_sync.sv
`timescale 1ns/1ps
`default_nettype none
module dpi2c_sync (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [1:0] d,
   output logic [1:0] q
);
   logic [1:0] meta_r;

   // two stages; the first is read by nothing but the second
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         meta_r <= 2'h3;
         q <= 2'h3;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule
`default_nettype wire

// ===== verilog/dpi2c_tick.sv
`timescale 1ns/1ps
`default_nettype none
module dpi2c_tick (
   input wire logic sys_clk,
   input wire logic rst,
   output logic tick
);
   import dpi2c_pkg::*;
   logic [QTR_W-1:0] cnt_r;

   // free-running quarter-period divider
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_r <= QTR_ZERO;
      end else if (cnt_r == QTR_LAST) begin
         cnt_r <= QTR_ZERO;
      end else begin
         cnt_r <= cnt_r + 5'h01;
      end
   end

   assign tick = (cnt_r == QTR_LAST);
endmodule
`default_nettype wire

// ===== verilog/dpi2c_master.sv
// Behaviour
// - serial clock kept at or below 400kHz
// - lines rest high; start is data falling while clock high
// - stop is data rising while clock high, ends the transfer
// - repeated start keeps the bus; next byte is a fresh address
// - write sends address, command, data, framed by start and stop
// - each byte is eight bits plus a ninth acknowledge clock
// - missing acknowledge fails the transfer; master retries
// - read: address, then nine clocks per requested byte
// - master acknowledges bytes to continue; ends read with nack, stop (here only one byte is read, and it always gets a nack)
// - master never stops inside the clock high of its start
`timescale 1ns/1ps
`default_nettype none
module dpi2c_master (
   input wire logic sys_clk,
   input wire logic rst,
   input wire dpi2c_pkg::dpi2c_asel_e address_select_pin,
   input wire logic req_valid,
   output logic req_ready,
   input wire dpi2c_pkg::dpi2c_req_s req,
   output logic rsp_valid,
   output dpi2c_pkg::dpi2c_rsp_s rsp,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe
);
   import dpi2c_pkg::*;

   dpi2c_st_e st_r, st_nxt;
   dpi2c_op_e op_r;
   logic [1:0] q_r, pos_r, pos_nxt, tries_r;
   logic [2:0] bit_r;
   logic [7:0] shift_r, cmd_r, data_r, hi_cnt_r;
   logic [6:0] addr_r;
   logic samp_r, err_r, tick, step, stall, load, fail, finish, retry;
   logic rx_byte, scl_s, sda_s, scl_low_nxt, sda_low_nxt;
   logic [1:0] last_pos;
   logic [1:0] pins_s;
   dpi2c_rsp_s rsp_r;
   logic rsp_valid_r;

   dpi2c_tick u_tick (
      .sys_clk(sys_clk),
      .rst(rst),
      .tick(tick)
   );

   // pins cross in from the bus before anything looks at them
   dpi2c_sync u_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .d({scl_i, sda_i}),
      .q(pins_s)
   );
   assign scl_s = pins_s[1];
   assign sda_s = pins_s[0];

   // a released clock that is still low holds the quarter (stretching)
   assign stall = !scl_oe && !scl_s && (st_r != ST_IDLE);
   assign step = tick && !stall;
   assign rx_byte = (op_r == OP_READ) && (pos_r == POS_RX);
   assign req_ready = (st_r == ST_IDLE);

   // last byte position of each kind of transfer
   always_comb begin
      unique case (op_r)
         OP_READ: last_pos = POS_RX;
         OP_GCALL: last_pos = POS_CMD;
         default: last_pos = POS_DATA;
      endcase
   end

   // byte sent at each position
   function automatic logic [7:0] byte_of(input logic [1:0] p);
      logic [7:0] b;
      b = BYTE_IDLE;
      unique case (p)
         POS_ADDR: b = {addr_r, RW_WRITE};
         POS_CMD: b = (op_r == OP_GCALL) ? GCALL_RESET : cmd_r;
         POS_DATA: b = (op_r == OP_READ) ? {addr_r, RW_READ} : data_r;
         default: b = BYTE_IDLE; // released while the target answers
      endcase
      return b;
   endfunction

   // sequencing between start, bytes, acknowledges, restart and stop
   always_comb begin
      st_nxt = st_r;
      pos_nxt = pos_r;
      load = 1'b0;
      fail = 1'b0;
      finish = 1'b0;
      retry = 1'b0;
      if (st_r == ST_IDLE) begin
         if (req_valid) begin
            st_nxt = ST_START;
         end
      end else if (step && q_r == Q_3) begin
         unique case (st_r)
            ST_START: begin
               st_nxt = ST_BYTE;
               pos_nxt = POS_ADDR;
               load = 1'b1;
            end
            ST_BYTE: begin
               if (bit_r == BIT_ZERO) begin
                  st_nxt = ST_ACK;
               end
            end
            ST_ACK: begin
               if (!rx_byte && samp_r) begin
                  st_nxt = ST_STOP;
                  fail = 1'b1;
               end else if (pos_r == last_pos) begin
                  st_nxt = ST_STOP;
               end else if (op_r == OP_READ && pos_r == POS_CMD) begin
                  st_nxt = ST_RSTART;
                  pos_nxt = POS_DATA;
               end else begin
                  st_nxt = ST_BYTE;
                  pos_nxt = pos_r + 2'h1;
                  load = 1'b1;
               end
            end
            ST_RSTART: begin
               st_nxt = ST_BYTE;
               load = 1'b1;
            end
            ST_STOP: st_nxt = ST_FIN;
            ST_FIN: begin
               // whole transfer again, so a read restarts from its first bit
               if (err_r && tries_r != RETRY_MAX) begin
                  st_nxt = ST_START;
                  retry = 1'b1;
               end else begin
                  st_nxt = ST_IDLE;
                  finish = 1'b1;
               end
            end
            default: st_nxt = ST_IDLE;
         endcase
      end
   end

   // state and quarter of the current bit
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_r <= ST_IDLE;
         q_r <= Q_0;
      end else begin
         st_r <= st_nxt;
         if (st_r == ST_IDLE) begin
            q_r <= Q_0;
         end else if (step) begin
            q_r <= q_r + 2'h1;
         end
      end
   end

   // byte position and bit count
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pos_r <= POS_ADDR;
         bit_r <= BIT_LAST;
      end else begin
         pos_r <= pos_nxt;
         if (load) begin
            bit_r <= BIT_LAST;
         end else if (st_r == ST_BYTE && step && q_r == Q_3 && bit_r != BIT_ZERO) begin
            bit_r <= bit_r - 3'h1;
         end
      end
   end

   // shifter: sample as the high phase ends, shift once the clock is low again
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         shift_r <= BYTE_IDLE;
         samp_r <= 1'b1;
      end else begin
         if (step && q_r == Q_2 && (st_r == ST_BYTE || st_r == ST_ACK)) begin
            samp_r <= sda_s;
         end
         if (load) begin
            shift_r <= byte_of(pos_nxt);
         end else if (st_r == ST_BYTE && step && q_r == Q_3) begin
            shift_r <= {shift_r[6:0], samp_r};
         end
      end
   end

   // request latch; address built from how the select pin is strapped, except a general call, which uses GCALL_ADDR
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         op_r <= OP_WRITE;
         cmd_r <= CMD_WIPER;
         data_r <= BYTE_IDLE;
         addr_r <= GCALL_ADDR;
      end else if (st_r == ST_IDLE && req_valid) begin
         op_r <= req.op;
         cmd_r <= req.cmd;
         data_r <= req.data;
         if (req.op == OP_GCALL) begin
            addr_r <= GCALL_ADDR;
         end else begin
            unique case (address_select_pin)
               SEL_SUPPLY: addr_r <= {ADDR_HI, ALO_SUPPLY};
               SEL_OPEN: addr_r <= {ADDR_HI, ALO_OPEN};
               default: addr_r <= {ADDR_HI, ALO_GND};
            endcase
         end
      end
   end

   // failure flag and attempt count
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         err_r <= 1'b0;
         tries_r <= 2'h0;
      end else if (st_r == ST_IDLE) begin
         err_r <= 1'b0;
         tries_r <= 2'h0;
      end else if (fail) begin
         err_r <= 1'b1;
      end else if (retry) begin
         err_r <= 1'b0;
         tries_r <= tries_r + 2'h1;
      end
   end

   // answer: one-cycle pulse after the closing stop
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rsp_valid_r <= 1'b0;
         rsp_r <= '0;
      end else begin
         rsp_valid_r <= finish;
         if (st_r == ST_ACK && rx_byte && step && q_r == Q_3) begin
            rsp_r.rdata <= shift_r;
         end
         if (finish) begin
            rsp_r.ok <= !err_r;
            rsp_r.tries <= tries_r;
         end
      end
   end
   assign rsp_valid = rsp_valid_r;
   assign rsp = rsp_r;

   // pin levels per state and quarter; a 1 pulls the line low
   always_comb begin
      scl_low_nxt = 1'b0;
      sda_low_nxt = 1'b0;
      unique case (st_r)
         ST_START: begin
            sda_low_nxt = (q_r != Q_0);
            scl_low_nxt = (q_r == Q_2) || (q_r == Q_3);
         end
         ST_BYTE: begin
            scl_low_nxt = (q_r == Q_0) || (q_r == Q_3);
            sda_low_nxt = !rx_byte && !shift_r[7];
         end
         ST_ACK: begin
            // address and written bytes: released for the target's ack;
            // the single read byte is the last, so it gets a nack
            scl_low_nxt = (q_r == Q_0) || (q_r == Q_3);
         end
         ST_RSTART: begin
            scl_low_nxt = (q_r == Q_0) || (q_r == Q_3);
            sda_low_nxt = (q_r == Q_2) || (q_r == Q_3);
         end
         ST_STOP: begin
            scl_low_nxt = (q_r == Q_0);
            sda_low_nxt = (q_r == Q_0) || (q_r == Q_1);
         end
         default: begin
            scl_low_nxt = 1'b0;
            sda_low_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
      end else begin
         scl_oe <= scl_low_nxt;
         sda_oe <= sda_low_nxt;
      end
   end
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;

   // cycles the clock line has been released
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         hi_cnt_r <= HI_SAT;
      end else if (scl_oe) begin
         hi_cnt_r <= 8'h00;
      end else if (hi_cnt_r != HI_SAT) begin
         hi_cnt_r <= hi_cnt_r + 8'h01;
      end
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence s_start_edge;
      $rose(sda_oe) && !scl_oe;
   endsequence
   sequence s_stop_edge;
      $fell(sda_oe) && !scl_oe;
   endsequence

   property p_idle_released;
      st_r == ST_IDLE |=> !scl_oe && !sda_oe;
   endproperty
   a_idle_released: assert property (p_idle_released)
      else $error("bus not released while idle");

   property p_start_only_framed;
      s_start_edge |-> (st_r == ST_START || st_r == ST_RSTART);
   endproperty
   a_start_only_framed: assert property (p_start_only_framed)
      else $error("data fell with clock high outside start");

   property p_stop_only_framed;
      s_stop_edge |-> st_r == ST_STOP;
   endproperty
   a_stop_only_framed: assert property (p_stop_only_framed)
      else $error("data rose with clock high outside stop");

   property p_no_stop_in_start_high;
      s_start_edge |=> sda_oe [*8];
   endproperty
   a_no_stop_in_start_high: assert property (p_no_stop_in_start_high)
      else $error("data released too soon after start");

   property p_clock_high_time;
      $rose(scl_oe) |-> $past(hi_cnt_r) >= 8'(QTR_CYC);
   endproperty
   a_clock_high_time: assert property (p_clock_high_time)
      else $error("clock high phase too short");

   property p_ack_after_eight;
      $rose(st_r == ST_ACK) |-> $past(bit_r) == BIT_ZERO;
   endproperty
   a_ack_after_eight: assert property (p_ack_after_eight)
      else $error("acknowledge slot not after eight bits");

   property p_nack_on_read;
      st_r == ST_ACK && rx_byte |=> !sda_oe;
   endproperty
   a_nack_on_read: assert property (p_nack_on_read)
      else $error("last read byte was acknowledged");

   property p_missing_ack_fails;
      st_r == ST_ACK && !rx_byte && step && q_r == Q_3 && samp_r |=> err_r && st_r == ST_STOP;
   endproperty
   a_missing_ack_fails: assert property (p_missing_ack_fails)
      else $error("missing acknowledge not treated as failure");

   property p_rstart_in_read;
      $rose(st_r == ST_RSTART) |-> op_r == OP_READ && pos_r == POS_DATA;
   endproperty
   a_rstart_in_read: assert property (p_rstart_in_read)
      else $error("repeated start outside a read");

   property p_read_released;
      st_r == ST_BYTE && rx_byte |=> !sda_oe;
   endproperty
   a_read_released: assert property (p_read_released)
      else $error("master drove data during a read byte");

   property p_answer_after_stop;
      rsp_valid |-> $past(st_r == ST_FIN) && st_r == ST_IDLE;
   endproperty
   a_answer_after_stop: assert property (p_answer_after_stop)
      else $error("answer not after a stop");
endmodule
`default_nettype wire

// ===== bench/dpi2c_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module dpi2c_dev_model #(
   parameter logic [7:0] CP_OFF_CMD = 8'hA0, // arbitrary code
   parameter logic [7:0] CP_ON_CMD = 8'hA1 // arbitrary code
) (
   input wire logic scl,
   input wire logic sda,
   input wire dpi2c_pkg::dpi2c_asel_e strap,
   input wire logic slow,
   output logic sda_pull,
   output logic scl_pull,
   output logic [7:0] wiper_r,
   output logic [7:0] config_r
);
   import dpi2c_pkg::*;
   logic [7:0] sh;
   logic [7:0] cmd;
   logic [7:0] txb;
   logic [6:0] own;
   logic active, rd, gc, ack;
   int nbit, pos;

   // own address from the three-state strap
   assign own = {5'h0A, strap == SEL_SUPPLY ? 2'h3 : {1'b0, strap == SEL_OPEN}};

   // power-up state: midscale wiper, pump on
   initial begin
      wiper_r = 8'h80;
      config_r = 8'h80;
      {sda_pull, scl_pull, active, rd, gc, ack} = 6'h00;
      cmd = 8'h00;
      nbit = 0;
      pos = 0;
   end

   // start or repeated start drops any half-received byte
   always @(negedge sda) begin
      if (scl === 1'b1) begin
         active = 1'b1;
         rd = 1'b0;
         nbit = 0;
         pos = 0;
      end
   end

   // stop at any bit ends the frame; nothing unfinished is applied
   always @(posedge sda) begin
      if (scl === 1'b1) begin
         active = 1'b0;
      end
   end

   // bits taken while clock high; a byte acts only once complete
   always @(posedge scl) begin
      if (active && nbit == 8) begin
         nbit = 0;
      end else if (active) begin
         sh = {sh[6:0], sda};
         nbit++;
      end
      if (active && nbit == 8) begin
         if (pos == 0) begin
            gc = (sh == 8'h00);
            ack = gc || sh[7:1] == own;
            active = ack;
            rd = sh[0];
            txb = cmd == 8'h00 ? wiper_r : cmd == 8'h80 ? config_r : 8'hFF;
         end else if (rd) begin
            ack = 1'b0;
            txb = 8'hFF;
         end else if (gc) begin
            if (pos == 1 && sh == 8'h06) begin
               wiper_r = 8'h80;
               config_r = 8'h80;
            end
         end else if (pos == 1) begin
            cmd = sh;
         end else if (pos == 2) begin
            if (cmd == 8'h00) wiper_r = sh;
            if (cmd == CP_OFF_CMD) config_r[7] = 1'b0;
            if (cmd == CP_ON_CMD) config_r[7] = 1'b1;
         end
         pos++;
      end
   end

   // data moves only while clock low; slow mode stretches the low phase
   always @(negedge scl) begin
      if (!active) sda_pull = 1'b0;
      else if (nbit == 8) sda_pull = ack;
      else sda_pull = rd && pos > 0 && !txb[7 - nbit];
      if (slow) begin
         scl_pull = 1'b1;
         #3000 scl_pull = 1'b0;
      end
   end
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import dpi2c_pkg::*;
   localparam logic [7:0] CP_OFF = 8'hA0;
   localparam logic [7:0] CP_ON = 8'hA1;
   logic sys_clk, rst, req_valid, req_ready, rsp_valid, slow;
   logic scl_o, scl_oe, sda_o, sda_oe, dev_sda, dev_scl;
   logic [7:0] wiper, cfg;
   dpi2c_asel_e address_select_pin, dev_strap;
   dpi2c_req_s req;
   dpi2c_rsp_s rsp, got;
   wire scl, sda;
   int failures, samples_checked, pulses;
   realtime last_rise = -10000.0;

   // open-drain wires with pull-ups
   assign scl = !(scl_oe || dev_scl);
   assign sda = !(sda_oe || dev_sda);

   dpi2c_master DUT (
      .sys_clk(sys_clk),
      .rst(rst),
      .address_select_pin(address_select_pin),
      .req_valid(req_valid),
      .req_ready(req_ready),
      .req(req),
      .rsp_valid(rsp_valid),
      .rsp(rsp),
      .scl_i(scl),
      .scl_o(scl_o),
      .scl_oe(scl_oe),
      .sda_i(sda),
      .sda_o(sda_o),
      .sda_oe(sda_oe)
   );

   dpi2c_dev_model #(.CP_OFF_CMD(CP_OFF), .CP_ON_CMD(CP_ON)) dev (
      .scl(scl),
      .sda(sda),
      .strap(dev_strap),
      .slow(slow),
      .sda_pull(dev_sda),
      .scl_pull(dev_scl),
      .wiper_r(wiper),
      .config_r(cfg)
   );

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // clock pulses counted per transfer; a short period is a fault
   always @(posedge scl) begin
      pulses++;
      check("scl period short", 8'($realtime - last_rise < 2500.0), 8'h00);
      last_rise = $realtime;
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic close_out;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // one request through to its answer, then judge the answer;
   // each stop releases the clock once more, so pulses count it too
   task automatic xfer(input dpi2c_op_e op, input logic [7:0] c, input logic [7:0] d,
                       input logic e_ok, input logic [7:0] e_rd, input int e_pulses);
      int n;
      @(negedge sys_clk);
      pulses = 0;
      req_valid = 1'b1;
      req = {op, c, d};
      n = 0;
      while (req_ready !== 1'b1 && n < 100) begin
         @(negedge sys_clk);
         n++;
      end
      if (req_ready !== 1'b1) begin
         failures++;
         close_out();
      end
      @(negedge sys_clk);
      req_valid = 1'b0;
      n = 0;
      do begin
         @(posedge sys_clk);
         #1;
         n++;
      end while (rsp_valid !== 1'b1 && n < 40000);
      if (rsp_valid !== 1'b1) begin
         failures++;
         close_out();
      end
      got = rsp;
      check("ok", 8'(got.ok), 8'(e_ok));
      check("tries", 8'(got.tries), e_ok ? 8'h00 : 8'(RETRY_MAX));
      check("pulses", 8'(pulses), 8'(e_pulses));
      check("idle lines", 8'({scl, sda}), 8'h03);
      if (op == OP_READ) check("rdata", got.rdata, e_rd);
   endtask

   task automatic t_reset;
      check("scl_oe", 8'(scl_oe), 8'h00);
      check("sda_oe", 8'(sda_oe), 8'h00);
      check("drive lows", 8'({scl_o, sda_o}), 8'h00);
      check("ready", 8'(req_ready), 8'h01);
      xfer(OP_READ, CMD_WIPER, 8'h00, 1'b1, 8'h80, 38);
   endtask

   task automatic t_straps;
      dpi2c_asel_e s[3] = '{SEL_GND, SEL_OPEN, SEL_SUPPLY};
      logic [7:0] v[3] = '{8'h00, 8'h5A, 8'hFF};
      for (int i = 0; i < 3; i++) begin
         @(negedge sys_clk);
         address_select_pin = s[i];
         dev_strap = s[i];
         xfer(OP_WRITE, CMD_WIPER, v[i], 1'b1, 8'h00, 28);
         check("wiper", wiper, v[i]);
         xfer(OP_READ, CMD_WIPER, 8'h00, 1'b1, v[i], 38);
      end
   endtask

   task automatic t_unsup;
      xfer(OP_READ, 8'h55, 8'h00, 1'b1, 8'hFF, 38);
   endtask

   // pump off, on, off again, then general call restores both
   task automatic t_pump_gcall;
      xfer(OP_WRITE, CP_OFF, 8'h00, 1'b1, 8'h00, 28);
      xfer(OP_READ, CMD_CONFIG, 8'h00, 1'b1, 8'h00, 38);
      xfer(OP_WRITE, CP_ON, 8'h00, 1'b1, 8'h00, 28);
      xfer(OP_READ, CMD_CONFIG, 8'h00, 1'b1, 8'h80, 38);
      xfer(OP_WRITE, CP_OFF, 8'h00, 1'b1, 8'h00, 28);
      xfer(OP_WRITE, CMD_WIPER, 8'h33, 1'b1, 8'h00, 28);
      xfer(OP_GCALL, 8'h00, 8'h06, 1'b1, 8'h00, 19);
      check("gc wiper", wiper, 8'h80);
      check("gc config", cfg, 8'h80);
   endtask

   // wrong strap: target stays silent, controller retries then gives up
   task automatic t_foreign;
      @(negedge sys_clk);
      address_select_pin = SEL_SUPPLY;
      dev_strap = SEL_GND;
      xfer(OP_WRITE, CMD_WIPER, 8'h11, 1'b0, 8'h00, 40);
      check("wiper kept", wiper, 8'h80);
      dev_strap = SEL_SUPPLY;
   endtask

   // target stretches every low phase
   task automatic t_slow;
      slow = 1'b1;
      xfer(OP_WRITE, CMD_WIPER, 8'h96, 1'b1, 8'h00, 28);
      xfer(OP_READ, CMD_WIPER, 8'h00, 1'b1, 8'h96, 38);
      slow = 1'b0;
   endtask

   initial begin
      failures = 0;
      samples_checked = 0;
      pulses = 0;
      rst = 1'b1;
      req_valid = 1'b0;
      req = '0;
      slow = 1'b0;
      address_select_pin = SEL_GND;
      dev_strap = SEL_GND;
      repeat (10) @(posedge sys_clk);
      @(negedge sys_clk);
      rst = 1'b0;
      t_reset();
      t_straps();
      t_unsup();
      t_pump_gcall();
      t_foreign();
      t_slow();
      close_out();
   end
endmodule
`default_nettype wire
